// ==== rtl/rpa_pkg.sv ====
// register page addressing: constants and carrier types
// assumes one clock domain; host signals arrive synchronous to the clock
package rpa_pkg;
   localparam int unsigned DATA_W   = 8;
   localparam int unsigned ADDR_W   = 6;
   localparam int unsigned PAGE_W   = 3;
   localparam int unsigned IDX_W    = 3;
   localparam int unsigned NUM_REGS = 64;

   localparam logic [IDX_W-1:0]  PAGE_REG_IDX   = 3'h0;
   localparam int unsigned       PAGING_EN_BIT  = 7;
   localparam int unsigned       PAGE_NUM_LSB   = 0;
   localparam logic [DATA_W-1:0] PAGE_REG_RESET = 8'h00;
   localparam logic [DATA_W-1:0] REG_RESET      = 8'h00;
   localparam logic [DATA_W-1:0] PAGE_REG_MASK  = 8'h87;

   // one host bus cycle as seen by the device
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic              ale;
      logic [IDX_W-1:0]  addr_pin;
      logic [ADDR_W-1:0] mux_line;
      logic [DATA_W-1:0] wdata;
   } rpa_req_t;

   // access forwarded to the rest of the device
   typedef struct packed {
      logic              wr;
      logic              rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } rpa_acc_t;
endpackage

// ==== rtl/rpa_addr_asm.sv ====
// register page addressing: register address assembly
// assumes page and latched lines are held stable by the caller
`timescale 1ns/1ps
`default_nettype none
module rpa_addr_asm
   import rpa_pkg::*;
(
   input  wire logic              muxed,
   input  wire logic              paging_mode_enable,
   input  wire logic [PAGE_W-1:0] page_number,
   input  wire logic [IDX_W-1:0]  addr_pin,
   input  wire logic [ADDR_W-1:0] mux_line,
   output logic      [ADDR_W-1:0] reg_addr
);
   always_comb begin
      if (!muxed) begin
         reg_addr = {page_number, addr_pin};
      end else if (paging_mode_enable) begin
         reg_addr = {page_number, mux_line[IDX_W-1:0]};
      end else begin
         reg_addr = mux_line;
      end
   end
endmodule
`default_nettype wire

// ==== rtl/rpa_top.sv ====
// register page addressing: paged register bank with host access
// assumes host strobes are one-cycle pulses synchronous to MCLK
`timescale 1ns/1ps
`default_nettype none
module rpa_top (
   input  wire logic             MCLK,
   input  wire logic             RESET_N,
   input  wire logic             BUS_MUXED,
   input  wire rpa_pkg::rpa_req_t HOST_REQ,
   output logic [7:0]            RDATA,
   output logic                  RVALID,
   output rpa_pkg::rpa_acc_t     REG_ACC,
   output logic                  PAGING_MODE_ENABLE,
   output logic [2:0]            PAGE_NUMBER
);
   import rpa_pkg::*;

   // ------------------------------------------------------------
   // state
   // ------------------------------------------------------------
   typedef struct packed {
      logic [NUM_REGS-1:0][DATA_W-1:0] mem;
      logic [DATA_W-1:0]               page_reg;
      logic [ADDR_W-1:0]               mux_latch;
      logic [DATA_W-1:0]               rdata;
      logic                            rvalid;
      rpa_acc_t                        acc;
   } rpa_state_t;

   rpa_state_t        st_q;
   rpa_state_t        st_d;
   logic [ADDR_W-1:0] addr_now;
   logic [ADDR_W-1:0] mux_now;
   logic              page_hit;

   // ------------------------------------------------------------
   // address assembly
   // ------------------------------------------------------------
   // lines captured on ale are usable in the same cycle
   assign mux_now = HOST_REQ.ale ? HOST_REQ.mux_line : st_q.mux_latch;

   rpa_addr_asm u_asm (
      .muxed              (BUS_MUXED),
      .paging_mode_enable (st_q.page_reg[PAGING_EN_BIT]),
      .page_number        (st_q.page_reg[PAGE_NUM_LSB +: PAGE_W]),
      .addr_pin           (HOST_REQ.addr_pin),
      .mux_line           (mux_now),
      .reg_addr           (addr_now)
   );

   assign page_hit = (addr_now[IDX_W-1:0] == PAGE_REG_IDX);

   // ------------------------------------------------------------
   // next state
   // ------------------------------------------------------------
   always_comb begin
      st_d        = st_q;
      st_d.rvalid = 1'b0;
      st_d.acc.wr = 1'b0;
      st_d.acc.rd = 1'b0;
      if (HOST_REQ.ale) begin
         st_d.mux_latch = HOST_REQ.mux_line;
      end
      if (HOST_REQ.wr) begin
         st_d.acc.wr    = 1'b1;
         st_d.acc.addr  = addr_now;
         st_d.acc.wdata = HOST_REQ.wdata;
         if (page_hit) begin
            st_d.page_reg = HOST_REQ.wdata & PAGE_REG_MASK;
         end else begin
            st_d.mem[addr_now] = HOST_REQ.wdata;
         end
      end else if (HOST_REQ.rd) begin
         st_d.acc.rd   = 1'b1;
         st_d.acc.addr = addr_now;
         st_d.rvalid   = 1'b1;
         st_d.rdata    = page_hit ? st_q.page_reg : st_q.mem[addr_now];
      end
   end

   always_ff @(posedge MCLK or negedge RESET_N) begin
      if (!RESET_N) begin
         st_q.mem       <= {NUM_REGS{REG_RESET}};
         st_q.page_reg  <= PAGE_REG_RESET;
         st_q.mux_latch <= '0;
         st_q.rdata     <= '0;
         st_q.rvalid    <= 1'b0;
         st_q.acc       <= '0;
      end else begin
         st_q <= st_d;
      end
   end

   // ------------------------------------------------------------
   // outputs
   // ------------------------------------------------------------
   assign RDATA              = st_q.rdata;
   assign RVALID             = st_q.rvalid;
   assign REG_ACC            = st_q.acc;
   assign PAGING_MODE_ENABLE = st_q.page_reg[PAGING_EN_BIT];
   assign PAGE_NUMBER        = st_q.page_reg[PAGE_NUM_LSB +: PAGE_W];

   // ------------------------------------------------------------
   // checks
   // ------------------------------------------------------------
   default clocking cb @(posedge MCLK); endclocking
   default disable iff (!RESET_N);

   a_page_write_lands: assert property (
      HOST_REQ.wr && page_hit |=> PAGE_NUMBER == $past(HOST_REQ.wdata[2:0])
         && PAGING_MODE_ENABLE == $past(HOST_REQ.wdata[7]))
      else $error("page register write lost");

   a_page_read_mirror: assert property (
      HOST_REQ.rd && !HOST_REQ.wr && page_hit |=> RVALID
         && RDATA == {PAGING_MODE_ENABLE, 4'h0, PAGE_NUMBER})
      else $error("page register mirror read wrong");

   a_ded_addr_form: assert property (
      !BUS_MUXED && (HOST_REQ.wr || HOST_REQ.rd)
      |=> REG_ACC.addr == {$past(PAGE_NUMBER), $past(HOST_REQ.addr_pin)})
      else $error("dedicated address wrong");

   a_mux_paged_form: assert property (
      BUS_MUXED && PAGING_MODE_ENABLE && (HOST_REQ.wr || HOST_REQ.rd)
      |=> REG_ACC.addr == {$past(PAGE_NUMBER), $past(mux_now[2:0])})
      else $error("muxed paged address wrong");

   a_mux_linear_form: assert property (
      BUS_MUXED && !PAGING_MODE_ENABLE && (HOST_REQ.wr || HOST_REQ.rd)
      |=> REG_ACC.addr == $past(mux_now))
      else $error("muxed linear address wrong");

   a_old_page_used: assert property (
      !BUS_MUXED && HOST_REQ.wr && page_hit
      |=> REG_ACC.addr[5:3] == $past(PAGE_NUMBER))
      else $error("page write used new page too early");

   a_reg_write_back: assert property (
      HOST_REQ.wr && !page_hit ##1 HOST_REQ.rd && !HOST_REQ.wr
         && addr_now == $past(addr_now)
      |=> RDATA == $past(HOST_REQ.wdata, 2))
      else $error("register write not read back");

   a_read_pulse: assert property (
      HOST_REQ.rd && !HOST_REQ.wr |=> RVALID && REG_ACC.rd ##1 !RVALID || $past(HOST_REQ.rd))
      else $error("read answer missing");

   a_page_reserved: assert property (
      RDATA[6:3] == 4'h0 || !(REG_ACC.rd && REG_ACC.addr[2:0] == PAGE_REG_IDX))
      else $error("page register reserved bits set");

   c_page_switch:  cover property (HOST_REQ.wr && page_hit ##1 HOST_REQ.rd);
   c_mux_linear:   cover property (BUS_MUXED && !PAGING_MODE_ENABLE && HOST_REQ.rd);
   c_mux_paged:    cover property (BUS_MUXED && PAGING_MODE_ENABLE && HOST_REQ.wr && !page_hit);
   c_ded_high_pg:  cover property (!BUS_MUXED && PAGE_NUMBER == 3'h7 && HOST_REQ.rd);
endmodule
`default_nettype wire

// ==== dv/rpa_host_model.sv ====
// host processor model: drives one register access on the bus
// assumes the caller runs it from a single process, one access at a time
`timescale 1ns/1ps
`default_nettype none
module rpa_host_model
   import rpa_pkg::*;
(
   input  wire logic     mclk,
   output var  rpa_req_t host_req
);
   initial host_req = '0;

   // ------------------------------------------------------------
   // access: request for one cycle, then the strobes drop and the lines are driven to inverted values
   // ------------------------------------------------------------
   task automatic access(input logic m, input logic w, input logic [ADDR_W-1:0] a,
                         input logic [DATA_W-1:0] d);
      @(posedge mclk);
      host_req <= '{wr: w, rd: ~w, ale: m, addr_pin: a[2:0], mux_line: a, wdata: d};
      @(posedge mclk);
      host_req <= '{wr: 1'b0, rd: 1'b0, ale: 1'b0, addr_pin: ~a[2:0], mux_line: ~a, wdata: ~d};
   endtask
endmodule
`default_nettype wire

// ==== dv/tb_top.sv ====
// testbench: random paged and linear accesses against a reference model
// assumes the host model drives the bus and the design holds its own assertions
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   import rpa_pkg::*;
   logic              mclk, reset_n, bus_muxed, rvalid, pme;
   rpa_req_t          host_req;
   rpa_acc_t          reg_acc;
   logic [DATA_W-1:0] rdata, pg;
   logic [2:0]        pn;
   logic [DATA_W-1:0] mem [NUM_REGS];
   logic [17:0]       exp_q [$];
   int                fail_count = 0;
   int                n_tests = 0;

   rpa_top u_rpa_top (.MCLK(mclk), .RESET_N(reset_n), .BUS_MUXED(bus_muxed),
      .HOST_REQ(host_req), .RDATA(rdata), .RVALID(rvalid), .REG_ACC(reg_acc),
      .PAGING_MODE_ENABLE(pme), .PAGE_NUMBER(pn));
   rpa_host_model u_rpa_host_model (.mclk(mclk), .host_req(host_req));

   initial begin
      mclk = 1'b0;
      forever #2.5 mclk = ~mclk;
   end

   // ------------------------------------------------------------
   // checking
   // ------------------------------------------------------------
   task automatic print_verdict;
      if (fail_count == 0 && n_tests > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   task automatic check(input logic [17:0] got, input logic [17:0] exp);
      n_tests++;
      if (got !== exp) begin
         fail_count++;
         $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask

   // reference model: address assembly with the page value before the access
   task automatic op(input logic m, input logic w, input logic [5:0] a, input logic [7:0] d);
      logic [5:0] e;
      logic       hit;
      e = (!m || pg[7]) ? {pg[2:0], a[2:0]} : a;
      hit = (e[2:0] == PAGE_REG_IDX);
      if (w && hit) pg = d & PAGE_REG_MASK;
      else if (w) mem[e] = d;
      exp_q.push_back({pg[7], pg[2:0], e, w ? d : (hit ? pg : mem[e])});
      bus_muxed <= m;
      u_rpa_host_model.access(m, w, a, d);
   endtask

   always @(negedge mclk) begin
      if (reset_n === 1'b1 && (rvalid === 1'b1 || reg_acc.wr === 1'b1)) begin
         if (exp_q.size() == 0) check('1, '0);
         else check({pme, pn, reg_acc.addr, reg_acc.wr === 1'b1 ? reg_acc.wdata : rdata},
                    exp_q.pop_front());
         if (rvalid === 1'b1) check(18'(reg_acc.rd), 18'h1);
      end
   end

   // ------------------------------------------------------------
   // stimulus
   // ------------------------------------------------------------
   initial begin
      logic [31:0] r;
      reset_n = 1'b0;
      bus_muxed = 1'b0;
      pg = '0;
      foreach (mem[i]) mem[i] = '0;
      void'($urandom(16309));
      repeat (3) @(posedge mclk);
      reset_n <= 1'b1;
      op(1'b0, 1'b0, 6'h00, 8'h00);
      for (int i = 0; i < 64; i++) op(1'b1, 1'b1, i[5:0], 8'(i * 3 + 1));
      for (int i = 0; i < 64; i++) op(1'b1, 1'b0, i[5:0], 8'h00);
      repeat (500) begin
         r = $urandom;
         op(r[0], r[1], r[7:2], r[15:8]);
      end
      repeat (3) @(posedge mclk);
      if (exp_q.size() != 0) check(18'(exp_q.size()), '0);
      print_verdict;
   end

   initial begin
      repeat (5000) @(posedge mclk);
      fail_count++;
      print_verdict;
   end
endmodule
`default_nettype wire
